// ===== core/smst_pkg.sv
// constants for the clocked-master serial transmitter: register map, bit fields, reset values
// assumes a single 200 MHz clock and the plain strobe register port of the top module
// Function
// [RULE1] reload shifter from buffer only after last bit out and only if buffer full
// [RULE2] buffer-to-shifter move takes one cycle, empties buffer, sets buffer-empty flag bit 4
// [RULE3] buffer-empty flag ignores irq enable, software cannot clear it, buffer write clears it
// [RULE4] irq request forwarded only while irq enable bit 4 is set
// [RULE5] shifter-empty status bit 1 is read-only, set when shifter empty, no irq
// [RULE6] shift register is not reachable by software
// [RULE7] tx enable bit 5 enables sending; nothing shifts until buffer loaded
// [RULE8] first bit driven on next rising shift clock edge, stable around falling edge
// [RULE9] baud generator held in reset while tx and both rx enables clear
// [RULE10] write into empty shifter moves straight through; words go back to back
// [RULE11] clearing tx enable aborts, resets transmitter, releases data and clock pins
// [RULE12] setting an rx enable aborts send, releases data pin; clock kept if master
// [RULE13] rx enable leaves transmitter state intact but off the pins
// [RULE14] single receive done clears its enable; send resumes if tx enable still set
// [RULE15] software clears tx enable first to stop resuming after single receive
// [RULE16] nine-bit select bit 6 makes words nine bits, ninth from bit 0
// [RULE17] ninth bit captured at the buffer-to-shifter move
// [RULE18] software writes ninth bit before buffer data in nine-bit mode
// [RULE19] setup: divisor, mode bits, irq and nine-bit, tx enable, ninth bit, data
// [RULE20] software sets global and peripheral irq enables for interrupts
// [RULE21] clocked mode bit 4, port enable bit 7 of rx status, master drives clock
// [RULE22] half duplex: no sending while receiving
// [RULE23] lsb first, one bit per shift clock period, ninth bit last
package smst_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_BAUD = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_HOLD = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_RX_STATUS = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_PFLAG = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_PENABLE = 4'h5;
  localparam int B_CLOCK_SOURCE_MASTER = 7;
  localparam int B_NINE = 6;
  localparam int B_TX_ENABLE = 5;
  localparam int B_SYNC = 4;
  localparam int B_SHIFTER_EMPTY_FLAG = 1;
  localparam int B_NINTH = 0;
  localparam int B_SERIAL_PORT_ENABLE = 7;
  localparam int B_SINGLE_RX_ENABLE = 5;
  localparam int B_CONTINUOUS_RX_ENABLE = 4;
  localparam int B_TXFLAG = 4;
  localparam int B_TX_IRQ_ENABLE = 4;
  localparam logic [DATA_W-1:0] RST_TX_STATUS = 8'h02;
  localparam logic [DATA_W-1:0] RST_BAUD = 8'h00;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
endpackage : smst_pkg

// ===== core/smst_top.sv
// clocked-master serial transmitter: holding buffer, hidden shifter, baud divider, pin drive
// assumes a same-clock register master and a receive path that pulses rx_word_done
`timescale 1ns/1ps
module smst_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [smst_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [smst_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [smst_pkg::DATA_W-1:0] reg_rdata,
  input wire logic rx_word_done,
  input wire logic shift_clk_line_i,
  output logic shift_clk_line_o,
  output logic shift_clk_line_oe,
  input wire logic serial_data_line_i,
  output logic serial_data_line_o,
  output logic serial_data_line_oe,
  output logic shift_clk_line_sync,
  output logic serial_data_line_sync,
  output logic tx_buffer_empty_flag,
  output logic tx_irq_req
);
  import smst_pkg::*;

  // control and status bits
  logic clock_source_master, nine_bit_tx_select, tx_enable, sync_mode, ninth_tx_bit;
  logic serial_port_enable, single_rx_enable, continuous_rx_enable, tx_irq_enable;
  logic [DATA_W-1:0] baud_divisor;
  logic [DATA_W-1:0] transmit_holding_buf;
  logic buf_full;
  // hidden shifter, never decoded on the register port
  logic [8:0] transmit_shift_reg;
  logic [3:0] bits_left;
  logic busy;
  logic phase;
  logic data_bit;
  logic [DATA_W-1:0] brg_cnt;
  logic [1:0] clk_meta, dat_meta;

  logic next_clock_source_master, next_nine_bit_tx_select, next_tx_enable, next_sync_mode;
  logic next_ninth_tx_bit, next_serial_port_enable, next_single_rx_enable;
  logic next_continuous_rx_enable, next_tx_irq_enable;
  logic [DATA_W-1:0] next_baud_divisor, next_transmit_holding_buf, next_rdata;
  logic next_buf_full, next_busy, next_phase, next_data_bit;
  logic [8:0] next_transmit_shift_reg;
  logic [3:0] next_bits_left;
  logic [DATA_W-1:0] next_brg_cnt;
  logic next_clk_o, next_clk_oe, next_dat_o, next_dat_oe, next_flag, next_irq;
  logic brg_hold, tick, rx_active, run, rise, fall, last_fall, do_load, hold_wr;

  always_comb begin
    rx_active = continuous_rx_enable | single_rx_enable;
    brg_hold = !tx_enable && !rx_active; // [RULE9]
    tick = !brg_hold && (brg_cnt == baud_divisor);
    next_brg_cnt = (brg_hold || tick) ? '0 : brg_cnt + 8'h01; // [RULE9]
    // receiving freezes the shifter rather than resetting it
    run = tx_enable && !rx_active; // [RULE22] [RULE13]
    rise = tick && !phase && run && busy;
    fall = tick && phase && run;
    last_fall = fall && (bits_left == 4'h0);
    hold_wr = reg_wr && (reg_addr == OFS_HOLD);
    do_load = tx_enable && buf_full && (!busy || last_fall); // [RULE1] [RULE7] [RULE10]
  end

  always_comb begin
    next_clock_source_master = clock_source_master;
    next_nine_bit_tx_select = nine_bit_tx_select;
    next_tx_enable = tx_enable;
    next_sync_mode = sync_mode;
    next_ninth_tx_bit = ninth_tx_bit;
    next_serial_port_enable = serial_port_enable;
    next_single_rx_enable = single_rx_enable;
    next_continuous_rx_enable = continuous_rx_enable;
    next_tx_irq_enable = tx_irq_enable;
    next_baud_divisor = baud_divisor;
    next_transmit_holding_buf = transmit_holding_buf;
    next_buf_full = buf_full;
    next_transmit_shift_reg = transmit_shift_reg;
    next_bits_left = bits_left;
    next_busy = busy;
    next_phase = phase;
    next_data_bit = data_bit;
    next_rdata = '0;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_TX_STATUS: begin
          // shifter-empty bit is not writable
          next_clock_source_master = reg_wdata[B_CLOCK_SOURCE_MASTER];
          next_nine_bit_tx_select = reg_wdata[B_NINE];
          next_tx_enable = reg_wdata[B_TX_ENABLE];
          next_sync_mode = reg_wdata[B_SYNC];
          next_ninth_tx_bit = reg_wdata[B_NINTH];
        end
        OFS_BAUD: next_baud_divisor = reg_wdata;
        OFS_RX_STATUS: begin
          next_serial_port_enable = reg_wdata[B_SERIAL_PORT_ENABLE]; // [RULE21]
          next_single_rx_enable = reg_wdata[B_SINGLE_RX_ENABLE];
          next_continuous_rx_enable = reg_wdata[B_CONTINUOUS_RX_ENABLE];
        end
        OFS_PENABLE: next_tx_irq_enable = reg_wdata[B_TX_IRQ_ENABLE];
        default: ;
      endcase
    end
    // flag register is read-only: writes to it land nowhere
    if (hold_wr) begin
      next_transmit_holding_buf = reg_wdata;
      next_buf_full = 1'b1; // [RULE3]
    end
    if (rx_word_done && single_rx_enable) begin
      next_single_rx_enable = 1'b0; // [RULE14]
    end
    if (rise) begin
      next_data_bit = transmit_shift_reg[0]; // [RULE8] [RULE23]
      next_transmit_shift_reg = {1'b0, transmit_shift_reg[8:1]};
      next_bits_left = bits_left - 4'h1;
      next_phase = 1'b1;
    end
    if (fall) begin
      next_phase = 1'b0; // data stays put across this edge
      if (last_fall) begin
        next_busy = 1'b0;
      end
    end
    if (do_load) begin
      // ninth bit sampled here, not at the buffer write
      next_transmit_shift_reg = {ninth_tx_bit, transmit_holding_buf}; // [RULE17] [RULE16]
      next_bits_left = nine_bit_tx_select ? BITS_9 : BITS_8; // [RULE16]
      next_busy = 1'b1;
      if (!hold_wr) begin
        next_buf_full = 1'b0; // [RULE2]
      end
    end
    if (!tx_enable) begin
      next_busy = 1'b0; // [RULE11]
      next_bits_left = 4'h0;
      next_phase = 1'b0;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_TX_STATUS: next_rdata = {clock_source_master, nine_bit_tx_select, tx_enable,
                                     sync_mode, 2'b00, !busy, ninth_tx_bit}; // [RULE5]
        OFS_BAUD: next_rdata = baud_divisor;
        OFS_HOLD: next_rdata = transmit_holding_buf; // [RULE6]
        OFS_RX_STATUS: next_rdata = {serial_port_enable, 1'b0, single_rx_enable,
                                     continuous_rx_enable, 4'h0};
        OFS_PFLAG: next_rdata = {3'b000, !buf_full, 4'h0}; // [RULE2]
        OFS_PENABLE: next_rdata = {3'b000, tx_irq_enable, 4'h0};
        default: next_rdata = '0;
      endcase
    end
  end

  always_comb begin
    next_flag = !next_buf_full; // [RULE3]
    next_irq = !next_buf_full && next_tx_irq_enable; // [RULE4]
    next_clk_o = next_phase;
    next_clk_oe = next_serial_port_enable && next_sync_mode && next_clock_source_master &&
                  (next_tx_enable || next_continuous_rx_enable || next_single_rx_enable);
    next_dat_o = next_data_bit;
    next_dat_oe = next_serial_port_enable && next_sync_mode && next_tx_enable &&
                  !next_continuous_rx_enable && !next_single_rx_enable; // [RULE12] [RULE11]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_source_master <= RST_TX_STATUS[B_CLOCK_SOURCE_MASTER];
      nine_bit_tx_select <= RST_TX_STATUS[B_NINE];
      tx_enable <= RST_TX_STATUS[B_TX_ENABLE];
      sync_mode <= RST_TX_STATUS[B_SYNC];
      ninth_tx_bit <= RST_TX_STATUS[B_NINTH];
      serial_port_enable <= 1'b0;
      single_rx_enable <= 1'b0;
      continuous_rx_enable <= 1'b0;
      tx_irq_enable <= 1'b0;
      baud_divisor <= RST_BAUD;
      transmit_holding_buf <= '0;
      buf_full <= 1'b0;
      transmit_shift_reg <= '0;
      bits_left <= 4'h0;
      busy <= 1'b0;
      phase <= 1'b0;
      data_bit <= 1'b0;
      brg_cnt <= '0;
      reg_rdata <= '0;
      tx_buffer_empty_flag <= 1'b1;
      tx_irq_req <= 1'b0;
      shift_clk_line_o <= 1'b0;
      shift_clk_line_oe <= 1'b0;
      serial_data_line_o <= 1'b0;
      serial_data_line_oe <= 1'b0;
    end else begin
      clock_source_master <= next_clock_source_master;
      nine_bit_tx_select <= next_nine_bit_tx_select;
      tx_enable <= next_tx_enable;
      sync_mode <= next_sync_mode;
      ninth_tx_bit <= next_ninth_tx_bit;
      serial_port_enable <= next_serial_port_enable;
      single_rx_enable <= next_single_rx_enable;
      continuous_rx_enable <= next_continuous_rx_enable;
      tx_irq_enable <= next_tx_irq_enable;
      baud_divisor <= next_baud_divisor;
      transmit_holding_buf <= next_transmit_holding_buf;
      buf_full <= next_buf_full;
      transmit_shift_reg <= next_transmit_shift_reg;
      bits_left <= next_bits_left;
      busy <= next_busy;
      phase <= next_phase;
      data_bit <= next_data_bit;
      brg_cnt <= next_brg_cnt;
      reg_rdata <= next_rdata;
      tx_buffer_empty_flag <= next_flag;
      tx_irq_req <= next_irq;
      shift_clk_line_o <= next_clk_o;
      shift_clk_line_oe <= next_clk_oe;
      serial_data_line_o <= next_dat_o;
      serial_data_line_oe <= next_dat_oe;
    end
  end

  // pin levels for the receive side; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_meta <= 2'b00;
      dat_meta <= 2'b00;
      shift_clk_line_sync <= 1'b0;
      serial_data_line_sync <= 1'b0;
    end else begin
      clk_meta <= {clk_meta[0], shift_clk_line_i};
      dat_meta <= {dat_meta[0], serial_data_line_i};
      shift_clk_line_sync <= clk_meta[1];
      serial_data_line_sync <= dat_meta[1];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reload_gate;
    do_load |-> buf_full && tx_enable && (!busy || (bits_left == 4'h0 && phase));
  endproperty
  a_reload_gate: assert property (p_reload_gate) else $error("reload while busy"); // [RULE1]

  property p_load_empties;
    do_load && !hold_wr |=> !buf_full && tx_buffer_empty_flag;
  endproperty
  a_load_empties: assert property (p_load_empties) else $error("buffer not emptied"); // [RULE2]

  property p_write_clears_flag;
    hold_wr |=> !tx_buffer_empty_flag;
  endproperty
  a_write_clears_flag: assert property (p_write_clears_flag) else $error("flag kept"); // [RULE3]

  property p_irq_gate;
    tx_irq_req |-> tx_irq_enable && tx_buffer_empty_flag;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // [RULE4]

  property p_shifter_status;
    reg_rd && reg_addr == OFS_TX_STATUS |=> reg_rdata[B_SHIFTER_EMPTY_FLAG] == $past(!busy);
  endproperty
  a_shifter_status: assert property (p_shifter_status) else $error("bad status"); // [RULE5]

  property p_no_shift_idle;
    !busy && !buf_full |=> !busy && !shift_clk_line_o;
  endproperty
  a_no_shift_idle: assert property (p_no_shift_idle) else $error("shift without data"); // [RULE7]

  property p_brg_hold;
    brg_hold |=> brg_cnt == '0;
  endproperty
  a_brg_hold: assert property (p_brg_hold) else $error("baud generator ran"); // [RULE9]

  property p_abort_tx;
    $fell(tx_enable) |-> (!serial_data_line_oe && !shift_clk_line_oe) ##1 (!busy && !phase);
  endproperty
  a_abort_tx: assert property (p_abort_tx) else $error("pins kept after abort"); // [RULE11]

  property p_rx_release;
    rx_active |-> !serial_data_line_oe;
  endproperty
  a_rx_release: assert property (p_rx_release) else $error("data driven in rx"); // [RULE12]

  property p_rx_freeze;
    rx_active && tx_enable && !hold_wr && !do_load |=> $stable(transmit_shift_reg);
  endproperty
  a_rx_freeze: assert property (p_rx_freeze) else $error("shifter moved in receive"); // [RULE13]

  property p_single_done;
    rx_word_done && single_rx_enable |=> !single_rx_enable;
  endproperty
  a_single_done: assert property (p_single_done) else $error("single rx kept"); // [RULE14]

  property p_word_len;
    do_load |=> bits_left == ($past(nine_bit_tx_select) ? BITS_9 : BITS_8);
  endproperty
  a_word_len: assert property (p_word_len) else $error("wrong word length"); // [RULE16]

  property p_lsb_first;
    rise |=> serial_data_line_o == $past(transmit_shift_reg[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong"); // [RULE23]

endmodule : smst_top

// ===== dv/smst_slave_model.sv
// far-side clocked serial receiver model, shifts in data on the falling shift clock
// assumes resolved pin levels from the bench and a word length changed only between words
// clr drops a half-received word, since an aborted send leaves stray bits behind
`timescale 1ns/1ps
module smst_slave_model (
  input wire logic ck,
  input wire logic dt,
  input wire logic clr,
  input wire logic [3:0] nbits,
  output logic [8:0] word,
  output int unsigned words
);
  logic [8:0] sh;
  int unsigned cnt;
  initial begin
    sh = '0;
    cnt = 0;
    word = '0;
    words = 0;
  end
  // sample only at the falling edge: the sender holds data stable there
  // time zero skipped, the resolved net settles from unknown then
  always @(negedge ck or posedge clr) begin
    if (clr) begin
      cnt = 0;
    end else if ($time > 0) begin
      sh = {dt, sh[8:1]};
      cnt++;
      if (cnt == nbits) begin
        word = sh >> (9 - nbits);
        words++;
        cnt = 0;
      end
    end
  end
endmodule : smst_slave_model

// ===== dv/sync_master_serial_tx_tb.sv
// self-checking bench for the clocked-master serial transmitter
// assumes the strobe register port of smst_top and the slave model on the pins
`timescale 1ns/1ps
module sync_master_serial_tx_tb;
  import smst_pkg::*;
  typedef struct packed {logic [3:0] a; logic [7:0] d;} smst_row_s;
  logic clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rx_word_done = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic [DATA_W-1:0] reg_rdata;
  logic ck_o, ck_oe, dt_o, dt_oe, flag, irq;
  logic ck_sync, dt_sync;
  logic clr = 0;
  logic dt_last = 0;
  logic [3:0] nbits = BITS_8;
  logic [8:0] word;
  int unsigned words, fail_count = 0, checked = 0;
  realtime t1;
  smst_row_s rows [7] = '{'{4'h0, 8'h02}, '{4'h1, 8'h00}, '{4'h2, 8'h00}, '{4'h3, 8'h00},
                          '{4'h4, 8'h10}, '{4'h5, 8'h00}, '{4'hF, 8'h00}};
  // clock pin assumed pulled low; released data shows the inverse of its last level
  wire ck_pin = (ck_oe === 1'b1) ? ck_o : 1'b0;
  wire dt_pin = (dt_oe === 1'b1) ? dt_o : ~dt_last;
  always #2.5 clk = ~clk;
  always @(posedge clk) if (dt_oe) dt_last <= dt_o;
  smst_top smst_top_inst (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_word_done(rx_word_done), .shift_clk_line_i(ck_pin), .shift_clk_line_o(ck_o),
    .shift_clk_line_oe(ck_oe), .serial_data_line_i(dt_pin), .serial_data_line_o(dt_o),
    .serial_data_line_oe(dt_oe), .shift_clk_line_sync(ck_sync), .serial_data_line_sync(dt_sync),
    .tx_buffer_empty_flag(flag), .tx_irq_req(irq));
  smst_slave_model smst_slave_model_inst (.ck(ck_pin), .dt(dt_pin), .clr(clr), .nbits(nbits),
    .word(word), .words(words));
  task automatic give_verdict();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(nm, {1'b0, reg_rdata}, {1'b0, e});
  endtask : rd
  // bounded wait for the far side to have counted n words
  task automatic wait_words(input int unsigned n);
    for (int i = 0; i < 4000 && words < n; i++) @(posedge clk);
    if (words < n) begin
      fail_count++;
      $display("unexpected word count expected %0d seen %0d", n, words);
      give_verdict();
    end
  endtask : wait_words
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("flag after reset", 9'(flag), 9'h001);
    chk("irq after reset", 9'(irq), 9'h000);
    chk("pin enables after reset", 9'({ck_oe, dt_oe}), 9'h000);
    foreach (rows[i]) rd(rows[i].a, rows[i].d, "reset value");
    chk("synced pin levels", 9'({ck_sync, dt_sync}), 9'h001);
    wr(OFS_BAUD, 8'h07);
    wr(OFS_RX_STATUS, 8'h80);
    wr(OFS_PENABLE, 8'h10);
    wr(OFS_TX_STATUS, 8'hB0);
    wr(OFS_PFLAG, 8'h00);
    rd(OFS_PFLAG, 8'h10, "flag reg after clear try");
    rd(OFS_TX_STATUS, 8'hB2, "status idle");
    chk("irq enabled", 9'(irq), 9'h001);
    wr(OFS_PENABLE, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("irq masked", 9'(irq), 9'h000);
    wr(OFS_HOLD, 8'hA5);
    wr(OFS_HOLD, 8'h3C);
    #1 chk("flag with word waiting", 9'(flag), 9'h000);
    rd(OFS_TX_STATUS, 8'hB0, "status busy");
    wait_words(1);
    t1 = $realtime;
    chk("first word", word, 9'h0A5);
    wait_words(2);
    chk("word spacing", 9'(int'(($realtime - t1) / 5.0)), 9'd128);
    chk("second word", word, 9'h03C);
    chk("flag after drain", 9'(flag), 9'h001);
    nbits = BITS_9;
    wr(OFS_TX_STATUS, 8'hF1);
    wr(OFS_HOLD, 8'h55);
    wr(OFS_TX_STATUS, 8'hF0);
    wait_words(3);
    chk("nine bit captured ninth", word, 9'h155);
    wr(OFS_HOLD, 8'h0F);
    wait_words(4);
    chk("nine bit word", word, 9'h00F);
    nbits = BITS_8;
    wr(OFS_TX_STATUS, 8'h90);
    wr(OFS_HOLD, 8'h81);
    repeat (40) @(posedge clk);
    chk("no shift while disabled", 9'(words), 9'd4);
    chk("buffer kept", 9'(flag), 9'h000);
    wr(OFS_TX_STATUS, 8'hB0);
    wait_words(5);
    chk("word after late enable", word, 9'h081);
    wr(OFS_HOLD, 8'hFF);
    repeat (40) @(posedge clk);
    clr <= 1'b1;
    wr(OFS_TX_STATUS, 8'h90);
    repeat (3) @(posedge clk);
    #1 chk("pins after tx disable", 9'({ck_oe, dt_oe}), 9'h000);
    clr <= 1'b0;
    rd(OFS_TX_STATUS, 8'h92, "shifter reset");
    wr(OFS_TX_STATUS, 8'hB0);
    wr(OFS_HOLD, 8'h66);
    repeat (40) @(posedge clk);
    wr(OFS_RX_STATUS, 8'hA0);
    repeat (3) @(posedge clk);
    #1 chk("pins during receive", 9'({ck_oe, dt_oe}), 9'h002);
    rd(OFS_TX_STATUS, 8'hB0, "shifter kept");
    @(posedge clk);
    rx_word_done <= 1'b1;
    @(posedge clk);
    rx_word_done <= 1'b0;
    rd(OFS_RX_STATUS, 8'h80, "single receive cleared");
    chk("data drive resumed", 9'(dt_oe), 9'h001);
    wait_words(6);
    chk("word resumed after receive", word, 9'h066);
    wr(OFS_TX_STATUS, 8'h90);
    give_verdict();
  end
endmodule : sync_master_serial_tx_tb
